// ===== bf_detector.sv
/*
 * Breaker failure detector: initiation with optional current supervision and
 * seal-in, three individually enabled delayed paths, high-set and low-set
 * current checks, re-trip and a failure trip sealed in by a dropout timer.
 * Assumes operands and current magnitudes are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module bf_detector #(
    parameter int TICK_CYCLES = bf_pkg::TICK_CYCLES,
    parameter int DELAY_W = bf_pkg::DELAY_W,
    parameter int LEVEL_W = bf_pkg::LEVEL_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire bf_pkg::meas_s [2:0] src_i,
    input wire logic initiate_3p_i,
    input wire logic [2:0] initiate_ph_i,
    input wire logic block_i,
    input wire logic bkr_pos1_i,
    input wire logic bkr_pos2_i,
    input wire logic test_on_i,
    output logic [2:0] retrip_o,
    output logic trip_o,
    output bf_pkg::status_s status_o
);

    localparam int TW = $clog2(TICK_CYCLES);

    logic [bf_pkg::CTRL_W-1:0] ctrl;
    logic [DELAY_W-1:0] delay [bf_pkg::NUM_DELAYS];
    logic [LEVEL_W-1:0] level [bf_pkg::NUM_LEVELS];
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic func_en;
    logic three_pole;
    logic [1:0] src_sel;
    logic active;
    bf_pkg::meas_s meas;
    logic supv_det;
    logic hi_det;
    logic lo_det;
    logic init_raw;
    logic init_ok;
    logic seal;
    logic initiated;
    logic [2:0] ph_init;
    logic t1_done;
    logic t2_done;
    logic t3_done;
    logic lowset_done;
    logic cur_fault;
    logic early_op;
    logic main_op;
    logic slow_op;
    logic failed;
    logic trip_hold;
    logic dropout_done;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    // Control word written by software.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= bf_pkg::CTRL_RST;
        end else if (wr_i && (addr_i == bf_pkg::CTRL_ADDR)) begin
            ctrl <= wdata_i[bf_pkg::CTRL_W-1:0];
        end
    end

    // Delay words, one millisecond per count.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < bf_pkg::NUM_DELAYS; i++) begin
                delay[i] <= bf_pkg::DELAY_RST;
            end
        end else if (wr_i) begin
            for (int i = 0; i < bf_pkg::NUM_DELAYS; i++) begin
                if (addr_i == bf_pkg::DELAY_BASE + 8'(4 * i)) begin
                    delay[i] <= wdata_i[DELAY_W-1:0];
                end
            end
        end
    end

    // Pickup levels in steps of 0.001 pu.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < bf_pkg::NUM_LEVELS; i++) begin
                level[i] <= bf_pkg::LEVEL_RST;
            end
        end else if (wr_i) begin
            for (int i = 0; i < bf_pkg::NUM_LEVELS; i++) begin
                if (addr_i == bf_pkg::LEVEL_BASE + 8'(4 * i)) begin
                    level[i] <= wdata_i[LEVEL_W-1:0];
                end
            end
        end
    end

    // Read data appear in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= '0;
            if (addr_i == bf_pkg::CTRL_ADDR) begin
                rdata_o <= 32'(ctrl);
            end
            if (addr_i == bf_pkg::STATUS_ADDR) begin
                rdata_o <= 32'(status_o);
            end
            for (int i = 0; i < bf_pkg::NUM_DELAYS; i++) begin
                if (addr_i == bf_pkg::DELAY_BASE + 8'(4 * i)) begin
                    rdata_o <= 32'(delay[i]);
                end
            end
            for (int i = 0; i < bf_pkg::NUM_LEVELS; i++) begin
                if (addr_i == bf_pkg::LEVEL_BASE + 8'(4 * i)) begin
                    rdata_o <= 32'(level[i]);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    // Free-running divider giving one tick per millisecond.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

    // ------------------------------------------------------------------
    // Settings and current detectors
    // ------------------------------------------------------------------
    assign func_en = ctrl[bf_pkg::CTRL_EN_BIT];
    assign three_pole = ctrl[bf_pkg::CTRL_3POLE_BIT];
    assign src_sel = ctrl[bf_pkg::CTRL_SRC_LSB +: 2];
    assign active = func_en && !block_i;

    // Picks the measurement source; the unused code falls back to the line.
    always_comb begin
        case (src_sel)
            bf_pkg::FIRST_BREAKER_SOURCE: meas = src_i[1];
            bf_pkg::SECOND_BREAKER_SOURCE: meas = src_i[2];
            default: meas = src_i[0];
        endcase
    end

    // True when any phase exceeds its level, or the neutral in three-pole mode.
    function automatic logic over_level(input bf_pkg::meas_s m,
                                        input logic [LEVEL_W-1:0] ph_lvl,
                                        input logic [LEVEL_W-1:0] n_lvl,
                                        input logic tp);
        logic hit;
        hit = tp && (m.neutral > n_lvl);
        for (int p = 0; p < 3; p++) begin
            hit = hit || (m.phase[p] > ph_lvl);
        end
        return hit;
    endfunction : over_level

    // Detectors are evaluated every cycle on the selected source.
    assign supv_det = over_level(meas, level[bf_pkg::LVL_PH_SUPV],
                                 level[bf_pkg::LVL_N_SUPV], three_pole);
    assign hi_det = over_level(meas, level[bf_pkg::LVL_PH_HI],
                               level[bf_pkg::LVL_N_HI], three_pole);
    assign lo_det = over_level(meas, level[bf_pkg::LVL_PH_LO],
                               level[bf_pkg::LVL_N_LO], three_pole);

    // ------------------------------------------------------------------
    // Initiation and seal-in
    // ------------------------------------------------------------------
    // Per-phase initiates count only in single-pole mode.
    assign ph_init = three_pole ? 3'h0 : initiate_ph_i;
    assign init_raw = initiate_3p_i || (|ph_init);
    assign init_ok = active && init_raw &&
                     (!ctrl[bf_pkg::CTRL_SUPV_BIT] || supv_det);

    // Latch holds only while current stays above the supervision level.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seal <= 1'b0;
        end else begin
            seal <= active && ctrl[bf_pkg::CTRL_SEAL_BIT] &&
                    (init_ok || seal) && supv_det;
        end
    end

    assign initiated = active && (init_ok || seal);

    // Re-trip follows initiation; single-pole re-trips only the named poles until the seal-in latches, then all three.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            retrip_o <= 3'h0;
        end else if (!initiated) begin
            retrip_o <= 3'h0;
        end else if (three_pole || initiate_3p_i || seal) begin
            retrip_o <= 3'h7;
        end else begin
            retrip_o <= ph_init;
        end
    end

    // ------------------------------------------------------------------
    // Delayed paths
    // ------------------------------------------------------------------
    bf_ms_timer #(.WIDTH(DELAY_W)) early_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .run_i(initiated && ctrl[bf_pkg::CTRL_T1_BIT]),
        .delay_i(delay[bf_pkg::DLY_T1]),
        .done_o(t1_done)
    );

    bf_ms_timer #(.WIDTH(DELAY_W)) main_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .run_i(initiated && ctrl[bf_pkg::CTRL_T2_BIT]),
        .delay_i(delay[bf_pkg::DLY_T2]),
        .done_o(t2_done)
    );

    bf_ms_timer #(.WIDTH(DELAY_W)) slow_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .run_i(initiated && ctrl[bf_pkg::CTRL_T3_BIT] && !test_on_i),
        .delay_i(delay[bf_pkg::DLY_T3]),
        .done_o(t3_done)
    );

    // Low-set delay starts together with the high-set enable.
    bf_ms_timer #(.WIDTH(DELAY_W)) lowset_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .run_i(t1_done || t2_done),
        .delay_i(delay[bf_pkg::DLY_LOWSET]),
        .done_o(lowset_done)
    );

    // High-set is live from timeout; low-set only once its delay has run out.
    assign cur_fault = hi_det || (lowset_done && lo_det);
    assign early_op = t1_done && bkr_pos1_i && cur_fault;
    assign main_op = t2_done && cur_fault;
    assign slow_op = t3_done && bkr_pos2_i;
    assign failed = active && (early_op || main_op || slow_op);

    // ------------------------------------------------------------------
    // Trip output and seal-in
    // ------------------------------------------------------------------
    // Holds the trip after failure clears until the dropout timer expires.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trip_hold <= 1'b0;
        end else begin
            trip_hold <= active && (failed || (trip_hold && !dropout_done));
        end
    end

    bf_ms_timer #(.WIDTH(DELAY_W)) dropout_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .run_i(trip_hold && !failed),
        .delay_i(delay[bf_pkg::DLY_DROPOUT]),
        .done_o(dropout_done)
    );

    // Registered trip and status operands.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trip_o <= 1'b0;
            status_o <= '0;
        end else begin
            trip_o <= active && (failed || trip_hold);
            status_o.initiated <= initiated;
            status_o.early_op <= active && early_op;
            status_o.main_op <= active && main_op;
            status_o.slow_op <= active && slow_op;
            status_o.hiset_op <= active && (t1_done || t2_done) && hi_det;
            status_o.lowset_op <= active && lowset_done && lo_det;
            status_o.failed <= failed;
            status_o.trip <= active && (failed || trip_hold);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    fail_trips_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        failed |=> trip_o && status_o.failed)
        else $error("breaker failure did not raise the trip");
    disabled_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !func_en |=> !trip_o && (retrip_o == 3'h0) && !status_o.initiated)
        else $error("disabled element drove an output");
    block_stops_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        block_i |=> !trip_o && (retrip_o == 3'h0))
        else $error("block did not stop the element");
    retrip_now_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (init_ok && initiate_3p_i) |=> (retrip_o == 3'h7))
        else $error("initiation did not re-trip at once");
    supv_initiate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ctrl[bf_pkg::CTRL_SUPV_BIT] && !supv_det && !seal) |-> !initiated)
        else $error("initiation accepted below supervision level");
    seal_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (seal && !supv_det) |=> !seal)
        else $error("seal-in held without current");
    neutral_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!three_pole && (meas.phase[0] <= level[bf_pkg::LVL_PH_SUPV]) &&
         (meas.phase[1] <= level[bf_pkg::LVL_PH_SUPV]) &&
         (meas.phase[2] <= level[bf_pkg::LVL_PH_SUPV])) |-> !supv_det)
        else $error("neutral supervision acted in single-pole mode");
    slow_service_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        test_on_i |-> !slow_op)
        else $error("slow path ran with breaker out of service");
    trip_cause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(trip_o) |-> $past(early_op || main_op || slow_op))
        else $error("trip rose with no path complete");

endmodule : bf_detector

`default_nettype wire

// ===== bf_pkg.sv
/*
 * Shared constants and carrier types for the breaker failure detector:
 * register offsets, field positions, reset values, timing figures and the
 * packed structs that carry current magnitudes and status operands.
 * Assumes a 100 MHz processing clock and currents in steps of 0.001 pu.
 */
`default_nettype none
package bf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000; // One millisecond timer step.
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int DELAY_W = 16; // 0.000 to 65.535 s in 1 ms steps.
    localparam int LEVEL_W = 16; // 0.000 to 65.535 pu in 0.001 pu steps.

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] DELAY_BASE = 8'h04; // Five delay words follow.
    localparam logic [7:0] LEVEL_BASE = 8'h18; // Six level words follow.
    localparam logic [7:0] STATUS_ADDR = 8'h30;
    localparam int NUM_DELAYS = 5;
    localparam int NUM_LEVELS = 6;

    // Delay word indices.
    localparam int DLY_T1 = 0;
    localparam int DLY_T2 = 1;
    localparam int DLY_T3 = 2;
    localparam int DLY_LOWSET = 3;
    localparam int DLY_DROPOUT = 4;

    // Level word indices.
    localparam int LVL_PH_SUPV = 0;
    localparam int LVL_N_SUPV = 1;
    localparam int LVL_PH_HI = 2;
    localparam int LVL_N_HI = 3;
    localparam int LVL_PH_LO = 4;
    localparam int LVL_N_LO = 5;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_3POLE_BIT = 1;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_SUPV_BIT = 4;
    localparam int CTRL_SEAL_BIT = 5;
    localparam int CTRL_T1_BIT = 6;
    localparam int CTRL_T2_BIT = 7;
    localparam int CTRL_T3_BIT = 8;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h1F0;
    localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 16'h041A; // 1.050 pu.

    // Measurement source choices.
    localparam logic [1:0] LINE_SOURCE_SELECT = 2'h0;
    localparam logic [1:0] FIRST_BREAKER_SOURCE = 2'h1;
    localparam logic [1:0] SECOND_BREAKER_SOURCE = 2'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0][LEVEL_W-1:0] phase;
        logic [LEVEL_W-1:0] neutral;
    } meas_s;

    typedef struct packed {
        logic initiated;
        logic early_op;
        logic main_op;
        logic slow_op;
        logic hiset_op;
        logic lowset_op;
        logic failed;
        logic trip;
    } status_s;

    localparam int STATUS_W = 8;

endpackage : bf_pkg

`default_nettype wire

// ===== bf_ms_timer.sv
/*
 * Millisecond pickup timer used by every delayed path of the detector.
 * Assumes a one-cycle tick every millisecond from the parent module.
 */
`timescale 1ns/1ps
`default_nettype none

module bf_ms_timer #(
    parameter int WIDTH = bf_pkg::DELAY_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic [WIDTH-1:0] delay_i,
    output logic done_o
);

    logic [WIDTH-1:0] count;

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------

    // Counts ticks while running and restarts from zero when run drops.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else if (!run_i) begin
            count <= '0;
        end else if (tick_i && (count < delay_i)) begin
            count <= count + 1'b1;
        end
    end

    // Timeout holds while the qualifying condition stays and the count is met.
    assign done_o = run_i && (count >= delay_i);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    timer_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !run_i |=> (count == '0) && (!done_o || (delay_i == '0)))
        else $error("timer did not restart after run dropped");

    timer_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (run_i && (delay_i == '0)) |-> done_o)
        else $error("zero delay timer did not time out at once");

endmodule : bf_ms_timer

`default_nettype wire

// ===== bf_breaker_model.sv
/* Breaker model: carries the fault current on one chosen source and
   reports the breaker closed until it opens after a re-trip.
   Assumes one clock shared with the detector. */
`timescale 1ns/1ps
`default_nettype none

module bf_breaker_model #(
    parameter int OPEN_CYC = 20
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] retrip_i,
    input wire logic stuck_i,
    input wire logic [15:0] amps_i,
    input wire logic [1:0] sel_i,
    output bf_pkg::meas_s [2:0] src_o,
    output logic closed_o
);
    int cnt;

    // Opens OPEN_CYC+1 cycles into a re-trip unless stuck; a zero fault recloses it.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            closed_o <= 1'b1;
        end else if (amps_i == 16'h0000) begin
            cnt <= 0;
            closed_o <= 1'b1;
        end else if (retrip_i != 3'h0 && !stuck_i) begin
            cnt <= cnt + 1;
            if (cnt >= OPEN_CYC) begin
                closed_o <= 1'b0;
            end
        end
    end

    // An open breaker carries no current, and only the chosen source sees it.
    always_comb begin
        for (int s = 0; s < 3; s++) begin
            src_o[s].phase = {3{(closed_o && sel_i == s[1:0]) ? amps_i : 16'h0000}};
            src_o[s].neutral = 16'h0000;
        end
    end
endmodule : bf_breaker_model
`default_nettype wire

// ===== bf_detector_tb_top.sv
/* Self-checking bench for the breaker failure detector with a breaker model.
   Assumes a 100 MHz clock and a millisecond tick shortened to 10 cycles. */
`timescale 1ns/1ps
`default_nettype none

module bf_detector_tb_top;
    localparam logic [7:0] CTL = bf_pkg::CTRL_ADDR;
    localparam logic [7:0] T2A = bf_pkg::DELAY_BASE + 8'h04;
    localparam logic [7:0] DOA = bf_pkg::DELAY_BASE + 8'h10;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ini3 = 1'b0;
    logic [2:0] ini_ph = 3'h0;
    logic block_i = 1'b0;
    logic test_on_i = 1'b0;
    logic stuck = 1'b1;
    logic [15:0] amps = 16'h0000;
    logic [1:0] sel = 2'h0;
    logic closed;
    logic [31:0] rdata_o;
    logic [2:0] retrip_o;
    logic trip_o;
    bf_pkg::status_s status_o;
    bf_pkg::meas_s [2:0] src;
    int mismatches = 0;
    int checks = 0;

    bf_detector #(.TICK_CYCLES(10)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_i(src),
        .initiate_3p_i(ini3), .initiate_ph_i(ini_ph), .block_i(block_i),
        .bkr_pos1_i(closed), .bkr_pos2_i(closed), .test_on_i(test_on_i),
        .retrip_o(retrip_o), .trip_o(trip_o), .status_o(status_o));
    bf_breaker_model #(.OPEN_CYC(20)) breaker (.clk_i(clk_i), .nrst_i(nrst_i),
        .retrip_i(retrip_o), .stuck_i(stuck), .amps_i(amps), .sel_i(sel), .src_o(src),
        .closed_o(closed));

    // Free-running 100 MHz clock.
    initial forever #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic go(input int n);
        repeat (n) @(posedge clk_i);
    endtask : go

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data appear in the cycle after the strobe and hold until the next read; sample mid-cycle.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        cmp(rdata_o, e);
        @(posedge clk_i);
    endtask : rd_chk

    task automatic out_chk(input logic [2:0] rt, input logic tr);
        @(negedge clk_i);
        cmp({28'h0, retrip_o, trip_o}, {28'h0, rt, tr});
        @(posedge clk_i);
    endtask : out_chk

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask : done

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        go(3);
        nrst_i <= 1'b1;
        rd_chk(CTL, 32'h1F0);
        rd_chk(bf_pkg::DELAY_BASE, 32'h0);
        rd_chk(bf_pkg::LEVEL_BASE, 32'h41A);
        rd_chk(8'h3C, 32'h0);
        done("defaults");
        amps <= 16'h0800;
        ini3 <= 1'b1;
        go(5);
        out_chk(3'h0, 1'b0);
        wr(CTL, 32'h1F3);
        go(2);
        out_chk(3'h7, 1'b1);
        rd_chk(bf_pkg::STATUS_ADDR, 32'hFF);
        block_i <= 1'b1;
        go(2);
        out_chk(3'h0, 1'b0);
        done("trip and block");
        block_i <= 1'b0;
        ini3 <= 1'b0;
        amps <= 16'h041A;
        go(3);
        ini3 <= 1'b1;
        go(3);
        out_chk(3'h0, 1'b0);
        amps <= 16'h041B;
        go(3);
        out_chk(3'h7, 1'b1);
        amps <= 16'h0800;
        ini3 <= 1'b0;
        go(3);
        out_chk(3'h7, 1'b1);
        amps <= 16'h0100;
        go(3);
        out_chk(3'h0, 1'b0);
        done("supervision");
        wr(CTL, 32'h1D1);
        amps <= 16'h0800;
        ini_ph <= 3'h2;
        go(3);
        out_chk(3'h2, 1'b1);
        ini_ph <= 3'h0;
        done("single pole");
        // The breaker opens in time, so the main path must stay quiet.
        wr(CTL, 32'h093);
        wr(T2A, 32'h8);
        stuck <= 1'b0;
        ini3 <= 1'b1;
        go(100);
        out_chk(3'h0, 1'b0);
        stuck <= 1'b1;
        amps <= 16'h0000;
        go(2);
        amps <= 16'h0800;
        go(60);
        out_chk(3'h7, 1'b0);
        go(40);
        out_chk(3'h7, 1'b1);
        done("main path");
        wr(DOA, 32'h5);
        ini3 <= 1'b0;
        amps <= 16'h0000;
        go(20);
        out_chk(3'h0, 1'b1);
        go(60);
        out_chk(3'h0, 1'b0);
        wr(DOA, 32'h0);
        done("dropout");
        wr(CTL, 32'h103);
        test_on_i <= 1'b1;
        ini3 <= 1'b1;
        go(5);
        out_chk(3'h7, 1'b0);
        test_on_i <= 1'b0;
        go(3);
        out_chk(3'h7, 1'b1);
        done("slow path");
        ini3 <= 1'b0;
        sel <= 2'h2;
        amps <= 16'h0800;
        wr(T2A, 32'h0);
        wr(CTL, 32'h0D3);
        ini3 <= 1'b1;
        go(3);
        out_chk(3'h0, 1'b0);
        wr(CTL, 32'h0DB);
        go(2);
        out_chk(3'h7, 1'b1);
        done("source");
        // High-set raised out of reach, so only the delayed low-set may trip.
        ini3 <= 1'b0;
        wr(bf_pkg::LEVEL_BASE + 8'h08, 32'hFFFF);
        wr(bf_pkg::DELAY_BASE + 8'h0C, 32'h2);
        ini3 <= 1'b1;
        go(5);
        out_chk(3'h7, 1'b0);
        go(20);
        out_chk(3'h7, 1'b1);
        done("low-set");
        close_out();
    end

    // Cuts a hang short well after the expected few hundred cycles.
    initial begin
        #50000;
        mismatches++;
        close_out();
    end
endmodule : bf_detector_tb_top
`default_nettype wire
